// ==== core/idle_timer_pkg.sv ====
// package: constants, register map and period decode for the idle timers
package idle_timer_pkg;
  // ==========================================
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned EIGHTH_SEC_NS   = 125_000_000;
  localparam int unsigned EIGHTH_CYCLES   = EIGHTH_SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned EIGHTHS_PER_SEC = 8;
  localparam int unsigned SEC_PER_MIN     = 60;
  localparam int unsigned EIGHTHS_PER_MIN = EIGHTHS_PER_SEC * SEC_PER_MIN;
  localparam int unsigned CNT_W           = 13;
  // ==========================================
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_DISP_KBD   = 10'h056;
  localparam logic [9:0] IDX_STBY_SUSP  = 10'h057;
  localparam logic [9:0] IDX_GLB_CTRL1  = 10'h05a;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h060;
  localparam logic [9:0] IDX_IRQ_MASK   = 10'h061;
  localparam logic [7:0] RST_TIMEOUTS   = 8'h00;
  localparam logic [7:0] RST_CTRL       = 8'h00;
  localparam logic [3:0] RST_IRQ        = 4'h0;
  localparam int unsigned TRIG_DIS_BIT  = 6;
  // ==========================================
  // timer slots
  localparam int unsigned T_VRAM    = 0;
  localparam int unsigned T_KBD     = 1;
  localparam int unsigned T_SUSPEND = 2;
  localparam int unsigned T_STANDBY = 3;
  localparam int unsigned N_TIMERS  = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [CNT_W-1:0] period_t;

  // ==========================================
  // timeout code to period in eighths of a second
  function automatic period_t period_eighths(logic [3:0] code, logic vram_scale, period_t per_min);
    period_t c;
    c = {{(CNT_W-4){1'b0}}, code};
    if (vram_scale) begin
      if (code <= 4'h8) return c;
      return period_t'((c - period_t'(8)) * period_t'(64));
    end
    return period_t'(c * per_min);
  endfunction : period_eighths
endpackage : idle_timer_pkg

// ==== core/idle_if.sv ====
// interface: one idle timer's tick, restart, timeout code and expiry
`timescale 1ns/1ps
`default_nettype none
interface idle_if;
  logic       tick;
  logic       restart;
  logic [3:0] code;
  logic       expire;
  modport timer (input tick, input restart, input code, output expire);
  modport ctrl  (output tick, output restart, output code, input expire);
endinterface : idle_if
`default_nettype wire

// ==== core/idle_timer.sv ====
// one programmable idle timer counting eighth-second ticks
`timescale 1ns/1ps
`default_nettype none
module idle_timer #(
  parameter logic                      VRAM_SCALE = 1'b0,
  parameter idle_timer_pkg::period_t   PER_MIN    = idle_timer_pkg::period_t'(idle_timer_pkg::EIGHTHS_PER_MIN)
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // timer link
  idle_if.timer     port
);
  import idle_timer_pkg::*;

  period_t cnt_r;
  period_t target;
  logic    fired_r;
  logic    expire_r;

  assign target      = period_eighths(port.code, VRAM_SCALE, PER_MIN);
  assign port.expire = expire_r;

  // ==========================================
  // count, restart, expire once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r    <= '0;
      fired_r  <= 1'b0;
      expire_r <= 1'b0;
    end else begin
      expire_r <= 1'b0;
      if (port.code == 4'h0 || port.restart) begin
        cnt_r   <= '0;
        fired_r <= 1'b0;
      end else if (port.tick && !fired_r) begin
        if (period_t'(cnt_r + period_t'(1)) >= target) begin
          expire_r <= 1'b1;
          fired_r  <= 1'b1;
          cnt_r    <= '0;
        end else begin
          cnt_r <= period_t'(cnt_r + period_t'(1));
        end
      end
    end
  end
endmodule : idle_timer
`default_nettype wire

// ==== core/idle_timeout_timers.sv ====
// top: four idle timers behind an axi4-lite register slave
// ==========================================
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module idle_timeout_timers #(
  parameter int unsigned ADDR_W        = 12,
  parameter int unsigned EIGHTH_CYCLES = idle_timer_pkg::EIGHTH_CYCLES,
  parameter int unsigned PER_MIN       = idle_timer_pkg::EIGHTHS_PER_MIN
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // activity pins
  input  wire logic              vram_activity,
  input  wire logic              kbd_activity,
  input  wire logic              system_activity,
  // expiry to power management
  output logic [3:0]             idle_expire,
  output logic                   irq,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  import idle_timer_pkg::*;

  logic [7:0]        disp_kbd_r;
  logic [7:0]        stby_susp_r;
  logic [7:0]        ctrl_r;
  logic [3:0]        status_r;
  logic [3:0]        mask_r;
  logic [3:0]        expire_nxt;
  logic [3:0]        expire_r;
  logic [2:0]        act_s1_r;
  logic [2:0]        act_s2_r;
  logic [31:0]       pre_r;
  logic              tick_r;
  logic              aw_held_r;
  logic              w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              do_write;
  logic [9:0]        widx;
  logic [9:0]        ridx;
  logic [7:0]        rval;
  logic              rhit;
  logic              whit;

  // ==========================================
  // activity synchronisers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      act_s1_r <= 3'h0;
      act_s2_r <= 3'h0;
    end else begin
      act_s1_r <= {system_activity, kbd_activity, vram_activity};
      act_s2_r <= act_s1_r;
    end
  end

  // ==========================================
  // eighth-second prescaler
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_r  <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else if (pre_r >= EIGHTH_CYCLES - 1) begin
      pre_r  <= 32'h0000_0000;
      tick_r <= 1'b1;
    end else begin
      pre_r  <= pre_r + 32'h0000_0001;
      tick_r <= 1'b0;
    end
  end

  // ==========================================
  // timers
  idle_if t_if [N_TIMERS] ();

  assign t_if[T_VRAM].code    = disp_kbd_r[7:4];
  assign t_if[T_KBD].code     = disp_kbd_r[3:0];
  assign t_if[T_SUSPEND].code = stby_susp_r[7:4];
  assign t_if[T_STANDBY].code = stby_susp_r[3:0];
  assign t_if[T_VRAM].restart    = act_s2_r[0];
  assign t_if[T_KBD].restart     = act_s2_r[1];
  assign t_if[T_SUSPEND].restart = act_s2_r[2];
  assign t_if[T_STANDBY].restart = act_s2_r[2];

  for (genvar i = 0; i < N_TIMERS; i++) begin : g_tmr
    assign t_if[i].tick = tick_r;
    idle_timer #(
      .VRAM_SCALE (i == T_VRAM),
      .PER_MIN    (period_t'(PER_MIN))
    ) u_tmr (
      .clk    (clk),
      .resetn (resetn),
      .port   (t_if[i])
    );
    if (i == T_STANDBY) begin : g_gate
      assign expire_nxt[i] = t_if[i].expire & ~ctrl_r[TRIG_DIS_BIT];
    end else begin : g_pass
      assign expire_nxt[i] = t_if[i].expire;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      expire_r <= 4'h0;
    end else begin
      expire_r <= expire_nxt;
    end
  end
  assign idle_expire = expire_r;

  // ==========================================
  // write channel
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;
  assign widx          = awaddr_r[11:2];
  assign whit          = (awaddr_r[1:0] == 2'h0) && (widx == IDX_DISP_KBD || widx == IDX_STBY_SUSP ||
                         widx == IDX_GLB_CTRL1 || widx == IDX_IRQ_STATUS || widx == IDX_IRQ_MASK);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      awaddr_r     <= '0;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= whit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      disp_kbd_r  <= RST_TIMEOUTS;
      stby_susp_r <= RST_TIMEOUTS;
      ctrl_r      <= RST_CTRL;
      mask_r      <= RST_IRQ;
    end else if (do_write && whit && wstrb_r[0]) begin
      unique case (widx)
        IDX_DISP_KBD:  disp_kbd_r  <= wdata_r[7:0];
        IDX_STBY_SUSP: stby_susp_r <= wdata_r[7:0];
        IDX_GLB_CTRL1: ctrl_r      <= wdata_r[7:0] & 8'hfd;
        IDX_IRQ_MASK:  mask_r      <= wdata_r[3:0];
        default:       ;
      endcase
    end
  end

  // sticky status, set wins over write-one-to-clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_r <= RST_IRQ;
    end else if (do_write && widx == IDX_IRQ_STATUS && whit && wstrb_r[0]) begin
      status_r <= (status_r & ~wdata_r[3:0]) | expire_r;
    end else begin
      status_r <= status_r | expire_r;
    end
  end
  assign irq = |(status_r & mask_r);

  // ==========================================
  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign ridx          = s_axi_araddr[11:2];

  always_comb begin
    rhit = s_axi_araddr[1:0] == 2'h0;
    rval = 8'h00;
    unique case (ridx)
      IDX_DISP_KBD:   rval = disp_kbd_r;
      IDX_STBY_SUSP:  rval = stby_susp_r;
      IDX_GLB_CTRL1:  rval = ctrl_r;
      IDX_IRQ_STATUS: rval = {4'h0, status_r};
      IDX_IRQ_MASK:   rval = {4'h0, mask_r};
      default:        rhit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rhit ? {24'h00_0000, rval} : 32'h0000_0000;
      s_axi_rresp  <= rhit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : idle_timeout_timers
`default_nettype wire

// ==== dv/idle_timeout_timers_props.sv ====
// checker: port assertions for the idle timers
`timescale 1ns/1ps
`default_nettype none
module idle_timeout_timers_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // activity and expiry
  input wire logic        vram_activity,
  input wire logic        kbd_activity,
  input wire logic        system_activity,
  input wire logic [3:0]  idle_expire,
  input wire logic        irq,
  // register bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_reset_quiet: assert property (
    $rose(resetn) |-> idle_expire == 4'h0 && !irq && !s_axi_bvalid && !s_axi_rvalid) else $error("busy after reset");
  a_pulse_once: assert property (
    idle_expire != 4'h0 |=> (idle_expire & $past(idle_expire)) == 4'h0) else $error("expiry not one cycle");
  a_vram_restart: assert property (
    vram_activity [*5] |-> !idle_expire[0]) else $error("vram expiry while active");
  a_kbd_restart: assert property (
    kbd_activity [*5] |-> !idle_expire[1]) else $error("keyboard expiry while active");
  a_sys_restart: assert property (
    system_activity [*5] |-> idle_expire[3:2] == 2'h0) else $error("system expiry while active");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0) else $error("read answer late");
  a_write_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready) else $error("write taken while answer pending");
endmodule : idle_timeout_timers_props
bind idle_timeout_timers idle_timeout_timers_props idle_timeout_timers_props_i (
  .clk(clk), .resetn(resetn), .vram_activity(vram_activity), .kbd_activity(kbd_activity),
  .system_activity(system_activity), .idle_expire(idle_expire), .irq(irq), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

// ==== dv/idle_timeout_timers_tb.sv ====
// testbench: register and timer checks for the idle timers
`timescale 1ns/1ps
`default_nettype none
module idle_timeout_timers_tb;
  import idle_timer_pkg::*;
  localparam logic [11:0] A_DK = {IDX_DISP_KBD, 2'b00};
  localparam logic [11:0] A_SS = {IDX_STBY_SUSP, 2'b00};
  localparam logic [11:0] A_CT = {IDX_GLB_CTRL1, 2'b00};
  localparam logic [11:0] A_ST = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] A_MK = {IDX_IRQ_MASK, 2'b00};
  logic        clk = 1'b0, resetn = 1'b0;
  logic [2:0]  act = 3'h7;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        lazy = 1'b0;
  logic [1:0]  resp;
  wire logic [3:0]  idle_expire;
  wire logic [31:0] rdata;
  wire logic [1:0]  bresp, rresp;
  wire logic        irq, awready, wready, bvalid, arready, rvalid;
  int errors = 0, comparisons = 0;
  always #5 clk = ~clk;
  idle_timeout_timers #(.EIGHTH_CYCLES(4), .PER_MIN(2)) idle_timeout_timers_i (
    .clk(clk), .resetn(resetn), .vram_activity(act[0]), .kbd_activity(act[1]), .system_activity(act[2]),
    .idle_expire(idle_expire), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= !lazy;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
    end while (bvalid !== 1'b1 || bready !== 1'b1);
    resp = bresp; bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= !lazy;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready !== 1'b1) rready <= 1'b1;
    end while (rvalid !== 1'b1 || rready !== 1'b1);
    rd = rdata; resp = rresp; rready <= 1'b0;
  endtask : rdr
  // timer b from release of activity to expiry, p eighths of 4 cycles
  task automatic meas(input int b, input logic [11:0] a, input logic [7:0] v, input int p);
    int n, ai;
    ai = (b < 2) ? b : 2;
    n = 0;
    wr(a, v);
    @(posedge clk);
    act[ai] <= 1'b0;
    while (idle_expire[b] !== 1'b1 && n < p * 4 + 40) begin
      @(posedge clk);
      n++;
    end
    chk("expiry in window", 32'(n > p * 4 && n <= p * 4 + 4), 32'h1);
    act[ai] <= 1'b1;
    wr(a, 8'h00);
  endtask : meas
  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  initial begin
    #200_000;
    errors++;
    test_done();
  end
  initial begin
    int n;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rdr(A_DK); chk("disp reset", rd, 32'h0000_0000);
    rdr(A_SS); chk("stby reset", rd, 32'h0000_0000);
    lazy = 1'b1;
    wr(A_DK, 8'ha5);
    chk("write resp", 32'(resp), 32'(RESP_OKAY));
    rdr(A_DK); chk("disp rw", rd, 32'h0000_00a5);
    chk("read resp", 32'(resp), 32'(RESP_OKAY));
    wr(A_SS, 8'h3c); rdr(A_SS); chk("stby rw", rd, 32'h0000_003c);
    lazy = 1'b0;
    rdr(12'h200); chk("unmapped resp", 32'(resp), 32'(RESP_SLVERR));
    rdr(A_DK + 12'h001);
    chk("misaligned resp", 32'(resp), 32'(RESP_SLVERR));
    wr(12'h200, 8'h11);
    chk("unmapped write resp", 32'(resp), 32'(RESP_SLVERR));
    rdr(A_DK); chk("disp kept", rd, 32'h0000_00a5);
    wr(A_DK, 8'h00); wr(A_SS, 8'h00);
    $display("test registers done");
    for (int c = 1; c < 16; c++) meas(0, A_DK, {c[3:0], 4'h0}, c <= 8 ? c : (c - 8) * 64);
    for (int c = 1; c < 16; c += 14) begin
      meas(1, A_DK, {4'h0, c[3:0]}, c * 2);
      meas(2, A_SS, {c[3:0], 4'h0}, c * 2);
      meas(3, A_SS, {4'h0, c[3:0]}, c * 2);
    end
    $display("test periods done");
    rdr(A_ST); chk("status all", rd, 32'h0000_000f);
    @(posedge clk); chk("irq masked", 32'(irq), 32'h0);
    wr(A_MK, 8'h01); @(posedge clk); chk("irq unmasked", 32'(irq), 32'h1);
    wr(A_ST, 8'h01); @(posedge clk); chk("irq cleared", 32'(irq), 32'h0);
    rdr(A_ST); chk("status w1c", rd, 32'h0000_000e);
    wr(A_ST, 8'h0e);
    $display("test interrupt done");
    wr(A_CT, 8'h40); rdr(A_CT); chk("ctrl rw", rd, 32'h0000_0040);
    wr(A_SS, 8'h01);
    act[2] <= 1'b0;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (idle_expire[3] === 1'b1) n++;
    end
    act[2] <= 1'b1;
    chk("standby suppressed", 32'(n), 32'h0);
    rdr(A_ST); chk("status suppressed", rd, 32'h0000_0000);
    $display("test trigger disable done");
    wr(A_DK, 8'h5a);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rdr(A_DK); chk("disp second reset", rd, 32'h0000_0000);
    rdr(A_SS); chk("stby second reset", rd, 32'h0000_0000);
    rdr(A_CT); chk("ctrl second reset", rd, 32'h0000_0000);
    $display("test second reset done");
    test_done();
  end
endmodule : idle_timeout_timers_tb
`default_nettype wire
